// >>> vector_regs_defs.svh
`ifndef VECTOR_REGS_DEFS_SVH
`define VECTOR_REGS_DEFS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define VLEN          256
`define VBYTES        32
`define PBITS         32
`define LEGACY_BITS   128
`define NUM_VREG      32
`define NUM_PREG      16
`define NUM_GOV       8
`define VREG_IDX_W    5
`define PREG_IDX_W    4
`define GOV_IDX_W     3
`define BYTE_IDX_W    5
`define ELEM_IDX_W    5

`endif

// >>> vector_regs_pkg.sv
package vector_regs_pkg;
  `include "vector_regs_defs.svh"

  // element size, coded as log2 of the element width in bytes
  typedef enum logic [2:0] {
    ES8   = 3'h0,
    ES16  = 3'h1,
    ES32  = 3'h2,
    ES64  = 3'h3,
    ES128 = 3'h4
  } esize_t;

  typedef logic [`VLEN-1:0]  vword_t;
  typedef logic [`PBITS-1:0] pword_t;

  typedef struct packed {
    vword_t [`NUM_VREG-1:0] vreg;
    pword_t [`NUM_PREG-1:0] preg;
    pword_t                 fault_status_register;
    vword_t                 vecRdData;
    pword_t                 predRdData;
    pword_t                 faultRdData;
    logic                   faultRaise;
  } regfile_state_t;
endpackage

// >>> pred_lanes.sv
`timescale 1ns/1ps
`include "vector_regs_defs.svh"

// ----------------------------------------
// per-byte view of a predicate for one element size
// ----------------------------------------
module pred_lanes (
  input  wire logic                   [`PBITS-1:0] pred,
  input  wire vector_regs_pkg::esize_t              size,
  output logic                        [`PBITS-1:0] active,
  output logic                        [`PBITS-1:0] lead
);
  import vector_regs_pkg::*;

  logic [`BYTE_IDX_W-1:0] lowMask;

  assign lowMask = `BYTE_IDX_W'((6'h1 << size) - 6'h1);

  genvar b;
  generate
    for (b = 0; b < `PBITS; b++) begin : g_lane
      // lowest bit of the element owning this byte decides
      assign lead[b]   = ((`BYTE_IDX_W'(b) & lowMask) == '0);
      assign active[b] = pred[`BYTE_IDX_W'(b) & ~lowMask];
    end
  endgenerate
endmodule

// >>> scalable_vector_register_file.sv
`timescale 1ns/1ps
`include "vector_regs_defs.svh"

module scalable_vector_register_file (
  input  wire logic                                    ref_clk,
  input  wire logic                                    rst,
  // vector write
  input  wire logic                                    vecWrEn,
  input  wire logic                [`VREG_IDX_W-1:0]   vecWrReg,
  input  wire logic                [`VLEN-1:0]         vecWrData,
  input  wire vector_regs_pkg::esize_t                 vecWrSize,
  input  wire logic                                    vecWrPredicated,
  input  wire logic                                    vecWrZeroing,
  input  wire logic                [`GOV_IDX_W-1:0]    vecWrGov,
  input  wire logic                                    vecWrLegacy,
  input  wire logic                                    vecWrScalar,
  // vector read
  input  wire logic                                    vecRdEn,
  input  wire logic                [`VREG_IDX_W-1:0]   vecRdReg,
  input  wire logic                                    vecRdLegacy,
  output logic                     [`VLEN-1:0]         vecRdData,
  // predicate write
  input  wire logic                                    predWrEn,
  input  wire logic                [`PREG_IDX_W-1:0]   predWrReg,
  input  wire logic                [`PBITS-1:0]        predWrData,
  input  wire vector_regs_pkg::esize_t                 predWrSize,
  input  wire logic                                    predWrPermute,
  // predicate read
  input  wire logic                                    predRdEn,
  input  wire logic                [`PREG_IDX_W-1:0]   predRdReg,
  input  wire vector_regs_pkg::esize_t                 predRdSize,
  input  wire logic                                    predRdPermute,
  output logic                     [`PBITS-1:0]        predRdData,
  // fault status operations
  input  wire logic                                    faultSetAll,
  input  wire logic                                    faultWrEn,
  input  wire logic                [`PBITS-1:0]        faultWrData,
  input  wire logic                                    faultRdEn,
  input  wire logic                                    faultRdSetFlags,
  output logic                     [`PBITS-1:0]        faultRdData,
  // element load failure report
  input  wire logic                                    loadFail,
  input  wire logic                [`ELEM_IDX_W-1:0]   loadElem,
  input  wire vector_regs_pkg::esize_t                 loadSize,
  input  wire logic                [`GOV_IDX_W-1:0]    loadGov,
  input  wire logic                                    loadFirstFault,
  output logic                                         faultRaise
);
  import vector_regs_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  regfile_state_t cur;
  regfile_state_t next_cur;

  // ----------------------------------------
  // predicate views
  // ----------------------------------------
  pword_t wrGovPred;
  pword_t wrActive;
  pword_t predWrLead;
  pword_t predRdLead;
  pword_t loadGovPred;
  pword_t loadActive;

  // governing index is only three bits wide, so P8-P15 cannot govern
  assign wrGovPred   = cur.preg[{1'b0, vecWrGov}];
  assign loadGovPred = cur.preg[{1'b0, loadGov}];

  pred_lanes govLanes (
    .pred   (wrGovPred),
    .size   (vecWrSize),
    .active (wrActive),
    .lead   ()
  );

  pred_lanes predWrLanes (
    .pred   (predWrData),
    .size   (predWrSize),
    .active (),
    .lead   (predWrLead)
  );

  pred_lanes predRdLanes (
    .pred   (cur.preg[predRdReg]),
    .size   (predRdSize),
    .active (),
    .lead   (predRdLead)
  );

  pred_lanes loadLanes (
    .pred   (loadGovPred),
    .size   (loadSize),
    .active (loadActive),
    .lead   ()
  );

  // ----------------------------------------
  // load failure position
  // ----------------------------------------
  logic [8:0]              failByteWide;
  logic                    failInRange;
  logic [`BYTE_IDX_W-1:0]  failByte;
  pword_t                  belowFail;
  logic                    failIsFirstActive;
  logic                    failElemActive;

  assign failByteWide      = 9'({4'h0, loadElem} << loadSize);
  assign failInRange       = (failByteWide < 9'(`VBYTES));
  assign failByte          = failByteWide[`BYTE_IDX_W-1:0];
  assign belowFail         = (`PBITS'(1) << failByte) - `PBITS'(1);
  assign failElemActive    = loadActive[failByte];
  // nothing active below the failing element makes it the first active one
  assign failIsFirstActive = failElemActive && ((loadActive & belowFail) == '0);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    vword_t     nv;
    logic [5:0] elemBytes;
    nv        = cur.vreg[vecWrReg];
    elemBytes = 6'h1 << vecWrSize;
    next_cur  = cur;
    next_cur.faultRaise = 1'b0;

    // reads see the state left by earlier instructions
    if (vecRdEn) begin
      if (vecRdLegacy) begin
        next_cur.vecRdData = {{(`VLEN-`LEGACY_BITS){1'b0}},
                              cur.vreg[vecRdReg][`LEGACY_BITS-1:0]};
      end else begin
        next_cur.vecRdData = cur.vreg[vecRdReg];
      end
    end

    if (predRdEn) begin
      if (predRdPermute) begin
        next_cur.predRdData = cur.preg[predRdReg];
      end else begin
        next_cur.predRdData = cur.preg[predRdReg] & predRdLead;
      end
    end

    // only the two fault read operations see the status register
    if (faultRdEn || faultRdSetFlags) begin
      next_cur.faultRdData = cur.fault_status_register;
    end

    // vector write, byte lanes walked from element zero upward
    if (vecWrEn) begin
      if (vecWrLegacy) begin
        nv = {{(`VLEN-`LEGACY_BITS){1'b0}}, vecWrData[`LEGACY_BITS-1:0]};
      end else if (vecWrScalar) begin
        for (int b = 0; b < `VBYTES; b++) begin
          if (6'(b) < elemBytes) begin
            nv[b*8 +: 8] = vecWrData[b*8 +: 8];
          end else begin
            nv[b*8 +: 8] = 8'h00;
          end
        end
      end else begin
        for (int b = 0; b < `VBYTES; b++) begin
          if (!vecWrPredicated || wrActive[b]) begin
            nv[b*8 +: 8] = vecWrData[b*8 +: 8];
          end else if (vecWrZeroing) begin
            nv[b*8 +: 8] = 8'h00;
          end
          // merging leaves the old byte in place
        end
      end
      next_cur.vreg[vecWrReg] = nv;
    end

    if (predWrEn) begin
      if (predWrPermute) begin
        next_cur.preg[predWrReg] = predWrData;
      end else begin
        next_cur.preg[predWrReg] = predWrData & predWrLead;
      end
    end

    // direct writers of the status register, then the indirect one
    if (faultSetAll) begin
      next_cur.fault_status_register = {`PBITS{1'b1}};
    end else if (faultWrEn) begin
      next_cur.fault_status_register = faultWrData;
    end

    if (loadFail && failInRange && failElemActive) begin
      if (loadFirstFault && failIsFirstActive) begin
        next_cur.faultRaise = 1'b1;
      end else begin
        // and-mask only, so a load can never raise a bit
        next_cur.fault_status_register = next_cur.fault_status_register & belowFail;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign vecRdData   = cur.vecRdData;
  assign predRdData  = cur.predRdData;
  assign faultRdData = cur.faultRdData;
  assign faultRaise  = cur.faultRaise;
endmodule

// >>> svrf_sva.sv
`timescale 1ns/1ps
module svrf_sva
  import vector_regs_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         vecRdEn,
  input wire logic         vecRdLegacy,
  input wire logic [255:0] vecRdData,
  input wire logic         predRdEn,
  input wire logic [31:0]  predRdData,
  input wire logic         faultSetAll,
  input wire logic         faultWrEn,
  input wire logic [31:0]  faultWrData,
  input wire logic         faultRdEn,
  input wire logic         faultRdSetFlags,
  input wire logic [31:0]  faultRdData,
  input wire logic         loadFail,
  input wire logic         loadFirstFault,
  input wire logic         faultRaise
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire faultRd = faultRdEn | faultRdSetFlags;
  sequence sSetAll;
    faultSetAll && !loadFail ##1 faultRd;
  endsequence
  property pDirectWr;
    logic [31:0] w;
    (faultWrEn && !faultSetAll && !loadFail, w = faultWrData) ##1 faultRd |=> faultRdData == w;
  endproperty
  chk_vec_hold: assert property (!vecRdEn |=> $stable(vecRdData)) else $error("vector data moved");
  chk_pred_hold: assert property (!predRdEn |=> $stable(predRdData)) else $error("predicate data moved");
  chk_fault_hold: assert property (!faultRd |=> $stable(faultRdData)) else $error("status data moved");
  chk_set_all: assert property (sSetAll |=> faultRdData == 32'hffff_ffff) else $error("set-all lost");
  chk_direct_wr: assert property (pDirectWr) else $error("status write lost");
  chk_legacy_view: assert property (vecRdEn && vecRdLegacy |=> vecRdData[255:128] == 128'h0)
    else $error("legacy view upper bits set");
  chk_raise_cause: assert property (faultRaise |-> $past(loadFail) && $past(loadFirstFault))
    else $error("fault raised without first-fault load");
  chk_no_raise: assert property (loadFail && !loadFirstFault |=> !faultRaise)
    else $error("non-fault load raised fault");
endmodule
bind scalable_vector_register_file svrf_sva u_sva (.*);

// >>> scalable_vector_register_file_tb_top.sv
`timescale 1ns/1ps
module scalable_vector_register_file_tb_top;
  import vector_regs_pkg::*;
  logic         ref_clk, rst, vecWrEn, vecWrPredicated, vecWrZeroing, vecWrLegacy, vecWrScalar;
  logic         vecRdEn, vecRdLegacy, predWrEn, predWrPermute, predRdEn, predRdPermute, faultSetAll;
  logic         faultWrEn, faultRdEn, faultRdSetFlags, loadFail, loadFirstFault, faultRaise;
  logic [4:0]   vecWrReg, vecRdReg, loadElem;
  logic [3:0]   predWrReg, predRdReg;
  logic [2:0]   vecWrGov, loadGov;
  logic [255:0] vecWrData, vecRdData;
  logic [31:0]  predWrData, predRdData, faultWrData, faultRdData;
  esize_t       vecWrSize, predWrSize, predRdSize, loadSize;
  int           badCount, nCompared;

  scalable_vector_register_file u_dut (.*);

  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end

  // strobes drop on the edge itself so the next request can rise 1 ns later
  task automatic cyc;
    @(posedge ref_clk);
    {vecWrEn, vecRdEn, predWrEn, predRdEn, faultSetAll, faultWrEn, faultRdEn, faultRdSetFlags, loadFail} <= '0;
    #1;
  endtask

  task automatic chk(string nm, logic [255:0] e, g);
    nCompared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      badCount++;
    end
  endtask

  // byte activity mask (lead=0) or canonical lead bits (lead=1)
  function automatic logic [31:0] lanes(logic [31:0] p, int s, bit lead);
    int st = s > 3 ? 16 : 1 << s;
    for (int b = 0; b < 32; b++) lanes[b] = lead ? p[b] && b % st == 0 : p[b - b % st];
  endfunction

  function automatic logic [255:0] vexp(logic [255:0] o, d, logic [31:0] m, bit z);
    for (int b = 0; b < 32; b++) vexp[b*8+:8] = m[b] ? d[b*8+:8] : z ? 8'h0 : o[b*8+:8];
  endfunction

  task automatic vw(logic [4:0] r, logic [255:0] d, int s, logic pd, z, lg, sc, logic [2:0] g);
    {vecWrEn, vecWrReg, vecWrData, vecWrPredicated, vecWrZeroing, vecWrLegacy, vecWrScalar, vecWrGov} =
      {1'b1, r, d, pd, z, lg, sc, g};
    vecWrSize = esize_t'(s);
    cyc;
  endtask

  task automatic vr(logic [4:0] r, logic lg, logic [255:0] e);
    {vecRdEn, vecRdReg, vecRdLegacy} = {1'b1, r, lg};
    cyc;
    chk("vecRdData", e, vecRdData);
  endtask

  task automatic pw(logic [3:0] r, logic [31:0] d, int s, logic raw);
    {predWrEn, predWrReg, predWrData, predWrPermute} = {1'b1, r, d, raw};
    predWrSize = esize_t'(s);
    cyc;
  endtask

  task automatic pr(logic [3:0] r, int s, logic raw, logic [31:0] e);
    {predRdEn, predRdReg, predRdPermute} = {1'b1, r, raw};
    predRdSize = esize_t'(s);
    cyc;
    chk("predRdData", e, predRdData);
  endtask

  task automatic fr(logic sf, logic [31:0] e);
    {faultRdEn, faultRdSetFlags} = {!sf, sf};
    cyc;
    chk("faultRdData", e, faultRdData);
  endtask

  task automatic printVerdict;
    if (badCount == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    logic [255:0] o, d;
    logic [31:0] p, f;
    logic [4:0] r;
    logic [2:0] g;
    int s, e;
    void'($urandom(32));
    {vecWrEn, vecWrPredicated, vecWrZeroing, vecWrLegacy, vecWrScalar, vecRdEn, vecRdLegacy, predWrEn,
     predWrPermute, predRdEn, predRdPermute, faultSetAll, faultWrEn, faultRdEn, faultRdSetFlags, loadFail,
     loadFirstFault, vecWrReg, vecRdReg, loadElem, predWrReg, predRdReg, vecWrGov, loadGov} = '0;
    {vecWrData, predWrData, faultWrData} = '0;
    vecWrSize = ES8;
    predWrSize = ES8;
    predRdSize = ES8;
    loadSize = ES8;
    rst = 1;
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 0;
    vr(5'h1f, 0, 0);
    fr(0, 0);
    for (int i = 0; i < 20; i++) begin
      s = i % 5;
      r = 5'($urandom);
      g = 3'($urandom);
      o = {8{$urandom}};
      d = {8{$urandom}};
      p = $urandom;
      pw({1'b0, g}, p, 0, 1);
      pw({1'b1, g}, p, s, 0);
      vw(r, o, 0, 0, 0, 0, 0, 0);
      vr(r, 1, {128'h0, o[127:0]});
      vw(r, d, s, 1, i > 9, 0, 0, g);
      vr(r, 0, vexp(o, d, lanes(p, s, 0), i > 9));
      pr({1'b0, g}, s, 0, lanes(p, s, 1));
      pr({1'b1, g}, s, 1, lanes(p, s, 1));
      vw(r, d, s, 1, 0, 1, 0, g);
      vr(r, 0, {128'h0, d[127:0]});
      vw(r, o, s, 1, 1, 0, 1, g);
      vr(r, 0, o & ((256'h1 << (8 << s)) - 1));
    end
    pw(0, 32'hffff_ffff, 0, 1);
    for (int i = 0; i < 8; i++) begin
      s = i % 4;
      e = $urandom % (32 >> s);
      p = $urandom;
      {faultSetAll, faultWrEn, faultWrData} = {2'b11, p};
      cyc;
      fr(i[0], 32'hffff_ffff);
      {loadFail, loadElem, loadGov, loadFirstFault} = {1'b1, 5'(e), 3'h0, i[1]};
      loadSize = esize_t'(s);
      cyc;
      chk("faultRaise", i[1] && e == 0, faultRaise);
      f = i[1] && e == 0 ? 32'hffff_ffff : (32'h1 << (e << s)) - 1;
      fr(0, f);
      {loadFail, loadElem, loadFirstFault} = {1'b1, 5'(31 >> s), 1'b0};
      cyc;
      fr(1, f & ((32'h1 << ((31 >> s) << s)) - 1));
      {faultWrEn, faultWrData} = {1'b1, p};
      cyc;
      fr(i[0], p);
    end
    printVerdict;
  end
endmodule
